// File: hdl/mstc_map.vh
// register offsets, field positions and limits of the statistics bank
`ifndef MSTC_MAP_VH
`define MSTC_MAP_VH

// byte offsets of the counters and of the local control word
`define MSTC_OFF_PAUSE_RX 8'h00
`define MSTC_OFF_TX_OK 8'h04
`define MSTC_OFF_ONE_COL 8'h08
`define MSTC_OFF_MANY_COL 8'h0C
`define MSTC_OFF_RX_OK 8'h10
`define MSTC_OFF_CRC_ERR 8'h14
`define MSTC_OFF_ALIGN_ERR 8'h18
`define MSTC_OFF_DEFER_TX 8'h1C
`define MSTC_OFF_CTRL 8'h20

// control word fields: mirror the network control / configuration bits
`define MSTC_CTRL_RX_EN 0
`define MSTC_CTRL_STAT_WE 7
`define MSTC_CTRL_BIG_FRAME 8
`define MSTC_RST_RX_EN 1'b0
`define MSTC_RST_STAT_WE 1'b0
`define MSTC_RST_BIG_FRAME 1'b0

// counter widths
`define MSTC_W16 16
`define MSTC_W24 24
`define MSTC_W8 8

// frame length limits in bytes
`define MSTC_LEN_MIN 11'd64
`define MSTC_LEN_MAX 11'd1518
`define MSTC_LEN_MAX_BIG 11'd1536

// collision count limits for the multi-collision counter
`define MSTC_COL_MANY_LO 5'd2
`define MSTC_COL_MANY_HI 5'd15

`endif

// File: hdl/mstc_counter.v
// one saturating, clear-on-read statistics counter
`timescale 1ns/1ps
`default_nettype none

module mstc_counter #(
  parameter WIDTH = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire inc,
  input wire rd_clr,
  input wire wr_en,
  input wire [31:0] wr_data,
  output reg [WIDTH-1:0] count_q
);

  reg [WIDTH-1:0] count_d;

  always @*
  begin
    count_d = count_q;
    if (wr_en)
    begin
      count_d = wr_data[WIDTH-1:0];
    end
    else if (rd_clr)
    begin
      // an event in the read cycle is lost; value was just returned
      count_d = {WIDTH{1'b0}};
    end
    else if (inc && (count_q != {WIDTH{1'b1}}))
    begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= {WIDTH{1'b0}};
    end
    else
    begin
      count_q <= count_d;
    end
  end

endmodule

`default_nettype wire

// File: hdl/mstc_stats.v
// statistics counter bank of a 10/100 mac with a wishbone slave
// What this block does
// - read returns value, then clears counter
// - counters stick at all ones
// - receive counters count only with rx enable
// - counter writes only take effect with bit 7
// - count good pause frames, 64..1518 bytes
// - bit 8 raises upper limit to 1536
// - count frames sent without underrun or retry limit
// - count good sends after exactly one collision
// - count good sends after 2..15 collisions
// - count good frames recognised and copied
// - count valid whole-byte frames with bad crc
// - whole-byte symbol errors also count as crc
// - count valid odd-bit frames with bad crc
// - odd-bit symbol errors also count as alignment
// - count first-attempt deferrals without collision or underrun
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "mstc_map.vh"

module mstc_stats #(
  parameter W_PAUSE = `MSTC_W16,
  parameter W_TX_OK = `MSTC_W24,
  parameter W_ONE = `MSTC_W16,
  parameter W_MANY = `MSTC_W16,
  parameter W_RX_OK = `MSTC_W24,
  parameter W_CRC = `MSTC_W8,
  parameter W_ALIGN = `MSTC_W8,
  parameter W_DEFER = `MSTC_W16
) (
  input wire clk_sys,
  input wire rst_n,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // receive frame end report, one-cycle pulse with qualifiers
  input wire rx_frame_done,
  input wire [10:0] rx_len,
  input wire rx_odd_bits,
  input wire rx_crc_bad,
  input wire rx_symbol_err,
  input wire rx_is_pause,
  input wire rx_addr_match,
  input wire rx_copied,
  // transmit frame end report, one-cycle pulse with qualifiers
  input wire tx_frame_done,
  input wire tx_underrun,
  input wire tx_retry_limit,
  input wire [4:0] tx_collisions,
  input wire tx_deferred,
  // local control bits, visible to the mac core
  output reg rx_enable_q,
  output reg big_frame_q
);

  // --------------------------------------------------------------
  // control register
  // --------------------------------------------------------------
  reg stat_we_q;
  // ack low keeps a held strobe from being taken twice
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req = req & wb_we_i;
  wire rd_req = req & ~wb_we_i;
  wire ctrl_hit = (wb_adr_i == `MSTC_OFF_CTRL);

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_enable_q <= `MSTC_RST_RX_EN;
      stat_we_q <= `MSTC_RST_STAT_WE;
      big_frame_q <= `MSTC_RST_BIG_FRAME;
    end
    else if (wr_req && ctrl_hit)
    begin
      if (wb_sel_i[0])
      begin
        rx_enable_q <= wb_dat_i[`MSTC_CTRL_RX_EN];
        stat_we_q <= wb_dat_i[`MSTC_CTRL_STAT_WE];
      end
      if (wb_sel_i[1])
      begin
        big_frame_q <= wb_dat_i[`MSTC_CTRL_BIG_FRAME];
      end
    end
  end

  // --------------------------------------------------------------
  // receive classification
  // --------------------------------------------------------------
  wire [10:0] len_max = big_frame_q ? `MSTC_LEN_MAX_BIG
                                    : `MSTC_LEN_MAX;
  wire len_ok = (rx_len >= `MSTC_LEN_MIN) && (rx_len <= len_max);
  wire rx_ev = rx_frame_done & rx_enable_q;
  wire rx_good = len_ok & ~rx_odd_bits & ~rx_crc_bad & ~rx_symbol_err;
  // a symbol error is booked like a bad crc
  wire rx_bad = rx_crc_bad | rx_symbol_err;

  wire inc_pause = rx_ev & rx_good & rx_is_pause;
  wire inc_rx_ok = rx_ev & rx_good & rx_addr_match
                   & rx_copied;
  // crc or symbol error on whole bytes
  wire inc_crc = rx_ev & len_ok & ~rx_odd_bits
                 & rx_bad;
  wire inc_align = rx_ev & len_ok & rx_odd_bits
                   & rx_bad;

  // --------------------------------------------------------------
  // transmit classification
  // --------------------------------------------------------------
  // transmit counters do not look at the receive enable
  wire tx_good = tx_frame_done & ~tx_underrun & ~tx_retry_limit;
  wire inc_tx_ok = tx_good;
  wire inc_one = tx_good & (tx_collisions == 5'd1);
  wire inc_many = tx_good & (tx_collisions >= `MSTC_COL_MANY_LO)
                  & (tx_collisions <= `MSTC_COL_MANY_HI);
  wire inc_defer = tx_frame_done & tx_deferred & ~tx_underrun
                   & (tx_collisions == 5'd0);

  // --------------------------------------------------------------
  // counter bank
  // --------------------------------------------------------------
  // writes without the enable are still acked, then dropped
  wire stat_wr = wr_req & stat_we_q;
  wire [7:0] inc_v = {inc_defer, inc_align, inc_crc, inc_rx_ok,
                      inc_many, inc_one, inc_tx_ok, inc_pause};

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  // one-hot on the byte offset; unmapped offsets hit nothing
  wire [7:0] hit_v;
  assign hit_v[0] = (wb_adr_i == `MSTC_OFF_PAUSE_RX);
  assign hit_v[1] = (wb_adr_i == `MSTC_OFF_TX_OK);
  assign hit_v[2] = (wb_adr_i == `MSTC_OFF_ONE_COL);
  assign hit_v[3] = (wb_adr_i == `MSTC_OFF_MANY_COL);
  assign hit_v[4] = (wb_adr_i == `MSTC_OFF_RX_OK);
  assign hit_v[5] = (wb_adr_i == `MSTC_OFF_CRC_ERR);
  assign hit_v[6] = (wb_adr_i == `MSTC_OFF_ALIGN_ERR);
  assign hit_v[7] = (wb_adr_i == `MSTC_OFF_DEFER_TX);
  // writes need all byte lanes so a partial write cannot tear a count
  wire full_sel = (wb_sel_i == 4'hF);
  wire [7:0] wr_v = hit_v & {8{stat_wr & full_sel}};
  wire [7:0] rd_v = hit_v & {8{rd_req}};

  wire [W_PAUSE-1:0] c_pause;
  wire [W_TX_OK-1:0] c_tx_ok;
  wire [W_ONE-1:0] c_one;
  wire [W_MANY-1:0] c_many;
  wire [W_RX_OK-1:0] c_rx_ok;
  wire [W_CRC-1:0] c_crc;
  wire [W_ALIGN-1:0] c_align;
  wire [W_DEFER-1:0] c_defer;

  // --------------------------------------------------------------
  // counter instances
  // --------------------------------------------------------------
  // good pause frames
  mstc_counter #(
    .WIDTH(W_PAUSE)
  ) u_pause (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(inc_v[0]),
    .rd_clr(rd_v[0]),
    .wr_en(wr_v[0]),
    .wr_data(wb_dat_i),
    .count_q(c_pause)
  );

  // frames sent ok
  mstc_counter #(
    .WIDTH(W_TX_OK)
  ) u_tx_ok (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(inc_v[1]),
    .rd_clr(rd_v[1]),
    .wr_en(wr_v[1]),
    .wr_data(wb_dat_i),
    .count_q(c_tx_ok)
  );

  // sent after one collision
  mstc_counter #(
    .WIDTH(W_ONE)
  ) u_one (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(inc_v[2]),
    .rd_clr(rd_v[2]),
    .wr_en(wr_v[2]),
    .wr_data(wb_dat_i),
    .count_q(c_one)
  );

  // sent after several collisions
  mstc_counter #(
    .WIDTH(W_MANY)
  ) u_many (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(inc_v[3]),
    .rd_clr(rd_v[3]),
    .wr_en(wr_v[3]),
    .wr_data(wb_dat_i),
    .count_q(c_many)
  );

  // good frames received and copied
  mstc_counter #(
    .WIDTH(W_RX_OK)
  ) u_rx_ok (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(inc_v[4]),
    .rd_clr(rd_v[4]),
    .wr_en(wr_v[4]),
    .wr_data(wb_dat_i),
    .count_q(c_rx_ok)
  );

  // whole-byte crc errors
  mstc_counter #(
    .WIDTH(W_CRC)
  ) u_crc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(inc_v[5]),
    .rd_clr(rd_v[5]),
    .wr_en(wr_v[5]),
    .wr_data(wb_dat_i),
    .count_q(c_crc)
  );

  // odd-bit crc errors
  mstc_counter #(
    .WIDTH(W_ALIGN)
  ) u_align (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(inc_v[6]),
    .rd_clr(rd_v[6]),
    .wr_en(wr_v[6]),
    .wr_data(wb_dat_i),
    .count_q(c_align)
  );

  // first-attempt deferrals
  mstc_counter #(
    .WIDTH(W_DEFER)
  ) u_defer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(inc_v[7]),
    .rd_clr(rd_v[7]),
    .wr_en(wr_v[7]),
    .wr_data(wb_dat_i),
    .count_q(c_defer)
  );

  // --------------------------------------------------------------
  // read mux and acknowledge
  // --------------------------------------------------------------
  reg [31:0] rd_d;

  always @*
  begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      `MSTC_OFF_PAUSE_RX:
      begin
        rd_d[W_PAUSE-1:0] = c_pause;
      end
      `MSTC_OFF_TX_OK:
      begin
        rd_d[W_TX_OK-1:0] = c_tx_ok;
      end
      `MSTC_OFF_ONE_COL:
      begin
        rd_d[W_ONE-1:0] = c_one;
      end
      `MSTC_OFF_MANY_COL:
      begin
        rd_d[W_MANY-1:0] = c_many;
      end
      `MSTC_OFF_RX_OK:
      begin
        rd_d[W_RX_OK-1:0] = c_rx_ok;
      end
      `MSTC_OFF_CRC_ERR:
      begin
        rd_d[W_CRC-1:0] = c_crc;
      end
      `MSTC_OFF_ALIGN_ERR:
      begin
        rd_d[W_ALIGN-1:0] = c_align;
      end
      `MSTC_OFF_DEFER_TX:
      begin
        rd_d[W_DEFER-1:0] = c_defer;
      end
      `MSTC_OFF_CTRL:
      begin
        rd_d[`MSTC_CTRL_RX_EN] = rx_enable_q;
        rd_d[`MSTC_CTRL_STAT_WE] = stat_we_q;
        rd_d[`MSTC_CTRL_BIG_FRAME] = big_frame_q;
      end
      default:
      begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // unmapped addresses still ack: reads give zero, writes are dropped
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      // read data holds between reads so a late sample still sees it
      if (rd_req)
      begin
        wb_dat_o <= rd_d;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/mstc_stats_asserts.sv
// port assertions for the statistics bank
`timescale 1ns/1ps
`default_nettype none
module mstc_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_enable_q,
  input wire logic big_frame_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_ack_o && !wb_we_i;
  endsequence
  sequence s_cw;
    wb_ack_o && wb_we_i && wb_adr_i == 8'h20 && wb_sel_i == 4'hF;
  endsequence
  property p_ack; s_take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack long");
  property p_rxen; s_cw |-> rx_enable_q == wb_dat_i[0]; endproperty
  a_rxen: assert property (p_rxen) else $error("rx enable");
  property p_big; s_cw |-> big_frame_q == wb_dat_i[8]; endproperty
  a_big: assert property (p_big) else $error("long frame");
  // the enable may move only on the edge that takes a control write
  property p_hold;
    !(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h20)
      |=> $stable(rx_enable_q);
  endproperty
  a_hold: assert property (p_hold) else $error("enable moved");
  property p_w8;
    s_rd ##0 wb_adr_i inside {8'h14, 8'h18} |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_w8: assert property (p_w8) else $error("8 bit width");
  property p_w16;
    s_rd ##0 wb_adr_i inside {8'h00, 8'h08, 8'h0C, 8'h1C}
      |-> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_w16: assert property (p_w16) else $error("16 bit width");
  property p_w24;
    s_rd ##0 wb_adr_i inside {8'h04, 8'h10} |-> wb_dat_o[31:24] == 8'h0;
  endproperty
  a_w24: assert property (p_w24) else $error("24 bit width");
endmodule
bind mstc_stats mstc_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_enable_q(rx_enable_q),
  .big_frame_q(big_frame_q));
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, rx_frame_done;
  logic rx_odd_bits, rx_crc_bad, rx_symbol_err, rx_is_pause, rx_addr_match;
  logic rx_copied, tx_frame_done, tx_underrun, tx_retry_limit, tx_deferred;
  logic [3:0] wb_sel_i;
  logic [7:0] wb_adr_i;
  logic [10:0] rx_len;
  logic [4:0] tx_collisions;
  logic [31:0] wb_dat_i, rd;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, rx_enable_q, big_frame_q;
  logic men, mbig, mwe;
  logic [3:0] bsel;
  integer errors, checks, seed, ticks, i, k;
  integer cnt[8] = '{default: 0};
  integer wid[8] = '{16, 24, 16, 16, 24, 8, 8, 16};
  integer lens[6] = '{63, 64, 1518, 1519, 1536, 1537};
  mstc_stats dut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_frame_done(rx_frame_done), .rx_len(rx_len),
    .rx_odd_bits(rx_odd_bits), .rx_crc_bad(rx_crc_bad),
    .rx_symbol_err(rx_symbol_err), .rx_is_pause(rx_is_pause),
    .rx_addr_match(rx_addr_match), .rx_copied(rx_copied),
    .tx_frame_done(tx_frame_done), .tx_underrun(tx_underrun),
    .tx_retry_limit(tx_retry_limit), .tx_collisions(tx_collisions),
    .tx_deferred(tx_deferred), .rx_enable_q(rx_enable_q),
    .big_frame_q(big_frame_q));
  task chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    wb_sel_i <= bsel;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task bump(integer j);
    if (cnt[j] < (1 << wid[j]) - 1) cnt[j]++;
  endtask
  task ctl(logic [31:0] d);
    bus(1'b1, 8'h20, d);
    {men, mwe, mbig} = {d[0], d[7], d[8]};
    chk("rx_enable", rx_enable_q, d[0]);
    chk("big_frame", big_frame_q, d[8]);
  endtask
  task wr(integer j, logic [31:0] d);
    bus(1'b1, 8'(j * 4), d);
    if (mwe && bsel == 4'hF) cnt[j] = d & ((1 << wid[j]) - 1);
  endtask
  task rdall(string n);
    for (k = 0; k < 8; k++)
    begin
      bus(1'b0, 8'(k * 4), 32'h0);
      chk(n, rd, cnt[k]);
      cnt[k] = 0;
    end
    $display("test %s done", n);
  endtask
  task rxev;
    logic [5:0] r;
    logic [10:0] l;
    logic v;
    r = 6'($random(seed));
    l = 11'(lens[$unsigned($random(seed)) % 6]);
    v = men && l >= 64 && l <= (mbig ? 1536 : 1518);
    @(posedge clk_sys);
    {rx_frame_done, rx_odd_bits, rx_crc_bad, rx_symbol_err, rx_is_pause,
      rx_addr_match, rx_copied, rx_len} <= {1'b1, r, l};
    if (v && r[5:3] == 0 && r[2]) bump(0);
    if (v && r[5:3] == 0 && r[1:0] == 3) bump(4);
    if (v && !r[5] && r[4:3] != 0) bump(5);
    if (v && r[5] && r[4:3] != 0) bump(6);
    @(posedge clk_sys);
    rx_frame_done <= 1'b0;
  endtask
  task txev;
    logic [4:0] c;
    logic [1:0] r;
    c = 5'($unsigned($random(seed)) % 17);
    r = 2'($random(seed));
    @(posedge clk_sys);
    {tx_frame_done, tx_underrun, tx_retry_limit, tx_collisions,
      tx_deferred} <= {1'b1, r[0], c == 5'h10, c, r[1]};
    if (!r[0] && c < 16) bump(1);
    if (!r[0] && c == 1) bump(2);
    if (!r[0] && c > 1 && c < 16) bump(3);
    if (!r[0] && c == 0 && r[1]) bump(7);
    @(posedge clk_sys);
    tx_frame_done <= 1'b0;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // a hung handshake must still reach the verdict
  always @(posedge clk_sys)
  begin
    ticks <= ticks + 1;
    if (ticks == 10000)
    begin
      errors++;
      finish_test;
    end
  end
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {rx_frame_done, rx_odd_bits, rx_crc_bad, rx_symbol_err} = '0;
    {rx_is_pause, rx_addr_match, rx_copied, rx_len} = '0;
    {tx_frame_done, tx_underrun, tx_retry_limit, tx_collisions} = '0;
    tx_deferred = 1'b0;
    wb_sel_i = 4'hF;
    bsel = 4'hF;
    {errors, checks, ticks} = '0;
    seed = 32'hDC2E;
    rst_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdall("reset");
    ctl(32'h1);
    for (i = 0; i < 8; i++) wr(i, $random(seed));
    rdall("locked");
    repeat (80)
    begin
      rxev;
      txev;
    end
    rdall("events");
    rdall("cleared");
    ctl(32'h101);
    repeat (80) rxev;
    rdall("long");
    ctl(32'h0);
    repeat (30) rxev;
    rdall("rx_off");
    ctl(32'h181);
    for (i = 0; i < 8; i++) wr(i, $random(seed));
    rdall("load");
    bus(1'b0, 8'h20, 32'h0);
    chk("ctrl", rd, {23'h0, mbig, mwe, 6'h0, men});
    bsel = 4'h3;
    for (i = 0; i < 8; i++) wr(i, $random(seed));
    bsel = 4'hF;
    rdall("lanes");
    for (i = 0; i < 8; i++) wr(i, 32'hFFFFFFFF);
    repeat (40)
    begin
      rxev;
      txev;
    end
    rdall("saturate");
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    finish_test;
  end
endmodule
`default_nettype wire
